/* hw/hcb_pkg.sv */
// Constants and types for the parallel register bus controller.
// Assumes a 100 MHz pclk and a device with 11 address and 16 data pins.
package hcb_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADDR_W        = 11;
   localparam int DATA_W        = 16;
   localparam int APB_AW        = 8;
   // Register offsets on APB
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_ADDR    = 8'h04;
   localparam logic [7:0] OFS_WDATA   = 8'h08;
   localparam logic [7:0] OFS_CMD     = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_RDATA   = 8'h14;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h20;
   // Control register fields
   localparam int CTRL_STROBE_MODE = 0;
   localparam int CTRL_WIDE        = 1;
   localparam int CTRL_SWAP        = 2;
   localparam int CTRL_MUX_ADDR    = 3;
   localparam int CTRL_W           = 4;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   // Command register fields
   localparam int CMD_START = 0;
   localparam int CMD_READ  = 1;
   // Interrupt status fields
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_DEV_INT = 1;
   localparam int IRQ_TIMEOUT = 2;
   localparam int IRQ_W       = 3;
   // Time allowed for the device to answer ready
   localparam int READY_TIMEOUT_NS  = 2560;
   localparam int READY_TIMEOUT_CYC = READY_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int TMO_W             = 9;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'b000001,
      ST_ADDR    = 6'b000010,
      ST_SETUP   = 6'b000100,
      ST_STROBE  = 6'b001000,
      ST_RECOVER = 6'b010000,
      ST_DONE    = 6'b100000
   } hcb_state_e;
endpackage

/* hw/hcb_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module hcb_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta[i] <= INIT[i];
               q[i]    <= INIT[i];
            end else begin
               meta[i] <= d[i];
               q[i]    <= meta[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

/* hw/hcb_host.sv */
// Host controller that runs register cycles on a parallel device bus.
// Assumes an APB master on pclk and device pins resolved by the bench.
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hcb_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic      [10:0] dev_addr,
   output logic             dev_ale,
   output logic             dev_cs_n,
   output logic             dev_rd_ds_n,
   output logic             dev_wr_rw,
   output logic             byte_lane_swap,
   output logic             dev_wide,
   output logic      [15:0] dev_data_out,
   output logic      [1:0]  dev_data_oe,
   input  wire logic [15:0] dev_data_in,
   input  wire logic        dev_ready_n,
   input  wire logic        dev_int_n
);
   logic [3:0]  ctrl;
   logic [10:0] addr_reg;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [2:0]  irq_status;
   logic [2:0]  irq_enable;
   logic [3:0]  op_cfg;
   logic        op_read;
   logic        busy;
   logic [8:0]  tmo;
   logic [15:0] data_s;
   logic        ready_n_s;
   logic        int_n_s;
   logic        int_n_d;
   logic        apb_setup;
   logic        apb_write;
   logic        start;
   logic        ready_seen;
   logic        timed_out;
   logic [3:0]  cur_cfg;
   logic        cur_read;
   hcb_pkg::hcb_state_e state;
   hcb_pkg::hcb_state_e next_state;

   // Lane order as the device applies it; swapping is its own inverse
   function automatic logic [15:0] lane_map(input logic [15:0] d,
                                            input logic [3:0] cfg);
      if (cfg[hcb_pkg::CTRL_WIDE] && cfg[hcb_pkg::CTRL_SWAP])
         return {d[7:0], d[15:8]};
      return d;
   endfunction

   hcb_sync #(.W(18), .INIT(18'h3FFFF)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({dev_int_n, dev_ready_n, dev_data_in}),
      .q       ({int_n_s, ready_n_s, data_s})
   );

   assign apb_setup = psel && !penable && !pready;
   assign apb_write = psel && penable && pready && pwrite;
   assign start     = apb_write && paddr == hcb_pkg::OFS_CMD &&
                      pwdata[hcb_pkg::CMD_START] && !busy;
   assign busy       = state != hcb_pkg::ST_IDLE;
   assign ready_seen = !ready_n_s;
   assign timed_out  = tmo == 9'(hcb_pkg::READY_TIMEOUT_CYC);
   // On the start edge op_cfg still holds the previous cycle's setting
   assign cur_cfg    = start ? ctrl : op_cfg;
   assign cur_read   = start ? pwdata[hcb_pkg::CMD_READ] : op_read;

   // APB slave: no wait states, read data registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= apb_setup;
         pslverr <= 1'b0;
         if (apb_setup) begin
            prdata <= 32'h0;
            unique case (paddr)
               hcb_pkg::OFS_CTRL:    prdata <= {28'h0, ctrl};
               hcb_pkg::OFS_ADDR:    prdata <= {21'h0, addr_reg};
               hcb_pkg::OFS_WDATA:   prdata <= {16'h0, wdata};
               hcb_pkg::OFS_STATUS:  prdata <= {30'h0, !int_n_s, busy};
               hcb_pkg::OFS_RDATA:   prdata <= {16'h0, rdata};
               hcb_pkg::OFS_IRQ_ST:  prdata <= {29'h0, irq_status};
               hcb_pkg::OFS_IRQ_EN:  prdata <= {29'h0, irq_enable};
               hcb_pkg::OFS_CMD,
               hcb_pkg::OFS_IRQ_CLR: prdata <= 32'h0;
               default:              pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Software registers; config locked while a cycle runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl       <= hcb_pkg::CTRL_RESET;
         addr_reg   <= 11'h0;
         wdata      <= 16'h0;
         irq_enable <= 3'h0;
      end else if (apb_write) begin
         if (paddr == hcb_pkg::OFS_CTRL && !busy)
            ctrl <= pwdata[3:0];
         if (paddr == hcb_pkg::OFS_ADDR && !busy)
            addr_reg <= pwdata[10:0];
         if (paddr == hcb_pkg::OFS_WDATA && !busy)
            wdata <= pwdata[15:0];
         if (paddr == hcb_pkg::OFS_IRQ_EN)
            irq_enable <= pwdata[2:0];
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 3'h0;
         int_n_d    <= 1'b1;
      end else begin
         int_n_d <= int_n_s;
         irq_status <= irq_status & ~((apb_write &&
                       paddr == hcb_pkg::OFS_IRQ_CLR) ? pwdata[2:0] : 3'h0);
         if (state == hcb_pkg::ST_DONE)
            irq_status[hcb_pkg::IRQ_DONE] <= 1'b1;
         if (int_n_d && !int_n_s)
            irq_status[hcb_pkg::IRQ_DEV_INT] <= 1'b1;
         if (state == hcb_pkg::ST_STROBE && timed_out && !ready_seen)
            irq_status[hcb_pkg::IRQ_TIMEOUT] <= 1'b1;
      end
   end

   assign irq = |(irq_status & irq_enable);

   always_comb begin
      next_state = state;
      unique case (state)
         hcb_pkg::ST_IDLE:
            if (start)
               next_state = ctrl[hcb_pkg::CTRL_MUX_ADDR] ?
                            hcb_pkg::ST_ADDR : hcb_pkg::ST_SETUP;
         hcb_pkg::ST_ADDR:    next_state = hcb_pkg::ST_SETUP;
         hcb_pkg::ST_SETUP:   next_state = hcb_pkg::ST_STROBE;
         hcb_pkg::ST_STROBE:
            if (ready_seen || timed_out)
               next_state = hcb_pkg::ST_RECOVER;
         hcb_pkg::ST_RECOVER: next_state = hcb_pkg::ST_DONE;
         hcb_pkg::ST_DONE:    next_state = hcb_pkg::ST_IDLE;
         default:             next_state = hcb_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         state <= hcb_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   // Operation captured at start so software cannot disturb a cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_cfg  <= hcb_pkg::CTRL_RESET;
         op_read <= 1'b0;
      end else if (start) begin
         op_cfg  <= ctrl;
         op_read <= pwdata[hcb_pkg::CMD_READ];
      end
   end

   // Ready wait bound; a dead device would otherwise hang the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tmo <= 9'h0;
      else if (state == hcb_pkg::ST_STROBE && !timed_out)
         tmo <= tmo + 9'h1;
      else if (state != hcb_pkg::ST_STROBE)
         tmo <= 9'h0;
   end

   // Read data taken when ready is seen, lanes put back in register order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rdata <= 16'h0;
      else if (state == hcb_pkg::ST_STROBE && ready_seen && op_read)
         rdata <= op_cfg[hcb_pkg::CTRL_WIDE] ?
                  lane_map(data_s, op_cfg) : {8'h0, data_s[7:0]};
   end

   // Device pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dev_addr       <= 11'h0;
         dev_ale        <= 1'b1;
         dev_cs_n       <= 1'b1;
         dev_rd_ds_n    <= 1'b1;
         dev_wr_rw      <= 1'b1;
         dev_data_out   <= 16'h0;
         dev_data_oe    <= 2'b00;
         byte_lane_swap <= 1'b0;
         dev_wide       <= 1'b0;
      end else begin
         byte_lane_swap <= cur_cfg[hcb_pkg::CTRL_SWAP];
         dev_wide       <= cur_cfg[hcb_pkg::CTRL_WIDE];
         unique case (next_state)
            hcb_pkg::ST_ADDR: begin
               dev_addr <= addr_reg;
               dev_ale  <= 1'b1;
            end
            hcb_pkg::ST_SETUP: begin
               dev_addr <= addr_reg;
               dev_ale  <= !cur_cfg[hcb_pkg::CTRL_MUX_ADDR];
               dev_cs_n <= 1'b0;
               dev_wr_rw <= cur_cfg[hcb_pkg::CTRL_STROBE_MODE] ?
                            cur_read : 1'b1;
               dev_data_out <= cur_cfg[hcb_pkg::CTRL_WIDE] ?
                  lane_map(wdata, cur_cfg) :
                  {8'h0, addr_reg[0] ? wdata[15:8] : wdata[7:0]};
               dev_data_oe <= cur_read ? 2'b00 :
                  {cur_cfg[hcb_pkg::CTRL_WIDE], 1'b1};
            end
            hcb_pkg::ST_STROBE: begin
               if (!op_cfg[hcb_pkg::CTRL_STROBE_MODE]) begin
                  dev_rd_ds_n <= !op_read;
                  dev_wr_rw   <= op_read;
               end else
                  dev_rd_ds_n <= 1'b0;
            end
            hcb_pkg::ST_RECOVER: begin
               dev_rd_ds_n <= 1'b1;
               dev_wr_rw   <= op_cfg[hcb_pkg::CTRL_STROBE_MODE] ?
                              op_read : 1'b1;
            end
            hcb_pkg::ST_DONE: begin
               dev_cs_n    <= 1'b1;
               dev_data_oe <= 2'b00;
            end
            default: begin
               dev_ale   <= 1'b1;
               dev_cs_n  <= 1'b1;
               dev_wr_rw <= 1'b1;
            end
         endcase
      end
   end

   sequence s_strobe_low;
      !dev_rd_ds_n || (!op_cfg[hcb_pkg::CTRL_STROBE_MODE] && !dev_wr_rw);
   endsequence

   chk_ale_non_mux: assert property (@(posedge pclk) disable iff (!presetn)
      !op_cfg[hcb_pkg::CTRL_MUX_ADDR] && !busy |=> dev_ale)
      else $error("latch strobe dropped without multiplexed addressing");

   chk_cs_strobe: assert property (@(posedge pclk) disable iff (!presetn)
      s_strobe_low |-> !dev_cs_n)
      else $error("strobe active without chip select");

   sequence s_cycle_open;
      state == hcb_pkg::ST_SETUP || state == hcb_pkg::ST_STROBE ||
      state == hcb_pkg::ST_RECOVER;
   endsequence

   chk_cs_whole_cycle: assert property (@(posedge pclk) disable iff (!presetn)
      s_cycle_open |-> !dev_cs_n)
      else $error("chip select lost during cycle");

   chk_sep_read: assert property (@(posedge pclk) disable iff (!presetn)
      state == hcb_pkg::ST_STROBE && !op_cfg[hcb_pkg::CTRL_STROBE_MODE] &&
      $past(state) == hcb_pkg::ST_STROBE |->
      dev_rd_ds_n == !op_read && dev_wr_rw == op_read)
      else $error("wrong separate strobe");

   chk_ds_dir: assert property (@(posedge pclk) disable iff (!presetn)
      op_cfg[hcb_pkg::CTRL_STROBE_MODE] && !dev_cs_n |->
      dev_wr_rw == op_read)
      else $error("direction line wrong in data strobe style");

   chk_strobe_ends: assert property (@(posedge pclk) disable iff (!presetn)
      state == hcb_pkg::ST_STROBE && ready_seen |=>
      state == hcb_pkg::ST_RECOVER ##1 state == hcb_pkg::ST_DONE ##1
      dev_cs_n && irq_status[hcb_pkg::IRQ_DONE])
      else $error("cycle did not close after ready");

   chk_no_drive_read: assert property (@(posedge pclk) disable iff (!presetn)
      op_read && busy |-> dev_data_oe == 2'b00)
      else $error("host drove data during a read");

   chk_byte_lane: assert property (@(posedge pclk) disable iff (!presetn)
      !dev_wide && dev_data_oe != 2'b00 |-> !dev_data_oe[1])
      else $error("high byte driven in byte width");
endmodule
`default_nettype wire

/* testbench/hcb_dev_model.sv */
// Behavioural parallel-bus register device facing the host controller.
// Assumes the bench resolves data, ready and interrupt lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module hcb_dev_model (
   input  wire logic        pclk,
   input  wire logic        rst_n,
   input  wire logic        mode,
   input  wire logic [10:0] addr,
   input  wire logic        ale,
   input  wire logic        cs_n,
   input  wire logic        rd_ds_n,
   input  wire logic        wr_rw,
   input  wire logic        swap,
   input  wire logic        wide,
   input  wire logic [15:0] data_in,
   input  wire logic [9:0]  ready_dly,
   input  wire logic        int_event,
   input  wire logic        int_clr,
   input  wire logic        int_hi_cfg,
   output logic      [15:0] data_out,
   output logic      [1:0]  data_oe,
   output logic             ready_out,
   output logic             ready_oe,
   output logic             int_out,
   output logic             int_oe
);
   logic [10:0] lat;
   logic [15:0] mem [0:1023];
   logic [15:0] word;
   logic [9:0]  cnt;
   logic        rd_act;
   logic        wr_act;
   logic        pend;
   logic        int_hi;
   always @* if (ale) lat = addr;
   assign rd_act = !cs_n && !rd_ds_n && (wr_rw || !mode);
   assign wr_act = !cs_n && (mode ? !rd_ds_n && !wr_rw : !wr_rw);
   assign word = mem[lat[10:1]];
   // Settable answer delay so the host sees prompt and slow cycles
   always @(posedge pclk)
      cnt <= (rd_act || wr_act) ? cnt + {9'h000, cnt != 10'h3FF} : 10'h000;
   assign ready_oe  = !cs_n;
   assign ready_out = !((rd_act || wr_act) && cnt >= ready_dly);
   assign data_oe   = rd_act ? {wide, 1'b1} : 2'b00;
   assign data_out  = wide ? (swap ? {word[7:0], word[15:8]} : word)
                           : {8'h00, lat[0] ? word[15:8] : word[7:0]};
   always @(posedge pclk)
      if (wr_act && wide)
         mem[lat[10:1]] <= swap ? {data_in[7:0], data_in[15:8]} : data_in;
      else if (wr_act && lat[0])
         mem[lat[10:1]][15:8] <= data_in[7:0];
      else if (wr_act)
         mem[lat[10:1]][7:0] <= data_in[7:0];
   always @(posedge pclk or negedge rst_n) begin
      if (!rst_n) begin
         pend   <= 1'b0;
         int_hi <= 1'b0;
      end else begin
         int_hi <= int_hi_cfg;
         pend   <= int_event || (pend && !int_clr);
      end
   end
   assign int_out = !pend;
   assign int_oe  = pend || int_hi;
endmodule
`default_nettype wire

/* testbench/hcb_host_bench.sv */
// Self-checking bench for the host controller against a device model.
// Assumes a 100 MHz pclk; pins are pulled up where nobody drives them.
`timescale 1ns/1ps
`default_nettype none
module hcb_host_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, re;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [10:0] dev_addr, a;
   logic        dev_ale, dev_cs_n, dev_rd_ds_n, dev_wr_rw, swp, wide;
   logic [15:0] h_do, m_do, d;
   logic [1:0]  h_oe, m_oe;
   logic        r_out, r_oe, i_out, i_oe, int_ev, int_clr, int_hi;
   logic [3:0]  cfg;
   logic [9:0]  dly;
   tri1  [15:0] dbus;
   tri1         rdy_w, int_w;
   int          n_errors, comparisons, cyc, n;
   assign dbus[7:0]  = h_oe[0] ? h_do[7:0] : 8'hZZ;
   assign dbus[15:8] = h_oe[1] ? h_do[15:8] : 8'hZZ;
   assign dbus[7:0]  = m_oe[0] ? m_do[7:0] : 8'hZZ;
   assign dbus[15:8] = m_oe[1] ? m_do[15:8] : 8'hZZ;
   assign rdy_w = r_oe ? r_out : 1'bZ;
   assign int_w = i_oe ? i_out : 1'bZ;
   hcb_host dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .dev_addr(dev_addr), .dev_ale(dev_ale), .dev_cs_n(dev_cs_n),
      .dev_rd_ds_n(dev_rd_ds_n), .dev_wr_rw(dev_wr_rw),
      .byte_lane_swap(swp), .dev_wide(wide), .dev_data_out(h_do),
      .dev_data_oe(h_oe), .dev_data_in(dbus), .dev_ready_n(rdy_w),
      .dev_int_n(int_w));
   hcb_dev_model peer (.pclk(pclk), .rst_n(presetn),
      .mode(cfg[hcb_pkg::CTRL_STROBE_MODE]), .addr(dev_addr), .ale(dev_ale),
      .cs_n(dev_cs_n), .rd_ds_n(dev_rd_ds_n), .wr_rw(dev_wr_rw), .swap(swp),
      .wide(wide), .data_in(dbus), .ready_dly(dly), .int_event(int_ev),
      .int_clr(int_clr), .int_hi_cfg(int_hi), .data_out(m_do),
      .data_oe(m_oe), .ready_out(r_out), .ready_oe(r_oe), .int_out(i_out),
      .int_oe(i_oe));
   always #5 pclk = !pclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] x,
                      input string m);
      comparisons++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
      end
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard well above the expected run length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   always @(posedge pclk) begin
      if (presetn && !dev_cs_n && !cfg[3] && dev_ale !== 1'b1) begin
         n_errors++;
         $display("wrong value at %0t: latch strobe low", $time);
      end
      if (presetn && !dev_rd_ds_n && dev_cs_n !== 1'b0) begin
         n_errors++;
         $display("wrong value at %0t: strobe without select", $time);
      end
      if (h_oe != 2'b00 && m_oe != 2'b00) begin
         n_errors++;
         $display("wrong value at %0t: data bus contention", $time);
      end
   end
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic dev_op(input logic r, input logic [10:0] ad, input logic [15:0] wd);
      apb(1'b1, hcb_pkg::OFS_ADDR, {21'h0, ad});
      apb(1'b1, hcb_pkg::OFS_WDATA, {16'h0, wd});
      apb(1'b1, hcb_pkg::OFS_CMD, {30'h0, r, 1'b1});
      do begin
         apb(1'b0, hcb_pkg::OFS_STATUS, 32'h0);
      end while (rv[0] !== 1'b0);
      apb(1'b0, hcb_pkg::OFS_RDATA, 32'h0);
   endtask
   // What the register holds, as seen through the chosen width
   function automatic logic [15:0] exp_val(input logic w, input logic [10:0] ad,
                                           input logic [15:0] v);
      return w ? v : {8'h00, ad[0] ? v[15:8] : v[7:0]};
   endfunction
   initial begin
      pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; cfg = 0; dly = 0; int_ev = 0; int_clr = 0; int_hi = 0;
      n_errors = 0; comparisons = 0; cyc = 0;
      n = $urandom(32'hC4361099);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({29'h0, dev_cs_n, dev_ale, irq}, 32'h6, "idle pins");
      apb(1'b0, hcb_pkg::OFS_CTRL, 32'h0);
      chk(rv, {28'h0, hcb_pkg::CTRL_RESET}, "control reset");
      $display("test reset done");
      for (int c = 0; c < 16; c++) begin
         cfg <= c[3:0];
         apb(1'b1, hcb_pkg::OFS_CTRL, {28'h0, c[3:0]});
         for (int k = 0; k < 2; k++) begin
            a = (k == 0) ? {10'h3FF, c[0]} : 11'($urandom);
            d = 16'($urandom);
            dly <= 10'($urandom % 6);
            dev_op(1'b0, a, d);
            chk({16'h0, exp_val(c[1], a, peer.mem[a[10:1]])}, {16'h0, exp_val(c[1], a, d)}, "stored");
            dev_op(1'b1, a, 16'h0);
            chk(rv, {16'h0, exp_val(c[1], a, d)}, "read back");
         end
         $display("test config %0d done", c);
      end
      dly <= 10'h190;
      dev_op(1'b1, 11'h002, 16'h0);
      apb(1'b0, hcb_pkg::OFS_IRQ_ST, 32'h0);
      chk(rv & 32'h5, 32'h5, "ready timeout flags");
      apb(1'b1, hcb_pkg::OFS_IRQ_CLR, 32'h7);
      apb(1'b0, hcb_pkg::OFS_IRQ_ST, 32'h0);
      chk(rv, 32'h0, "flags cleared");
      apb(1'b0, 8'h40, 32'h0);
      chk({rv[31:1], re}, 32'h1, "unmapped offset");
      $display("test timeout and unmapped done");
      dly <= 10'h000;
      int_hi <= 1'b1;
      apb(1'b1, hcb_pkg::OFS_IRQ_EN, 32'h2);
      @(posedge pclk) int_ev <= 1'b1;
      @(posedge pclk) int_ev <= 1'b0;
      n = 0;
      while (irq !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, irq}, 32'h1, "irq raised");
      apb(1'b0, hcb_pkg::OFS_STATUS, 32'h0);
      chk(rv & 32'h2, 32'h2, "source active");
      apb(1'b1, hcb_pkg::OFS_IRQ_EN, 32'h0);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      apb(1'b1, hcb_pkg::OFS_IRQ_EN, 32'h2);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h1, "irq unmasked");
      @(posedge pclk) int_clr <= 1'b1;
      @(posedge pclk) int_clr <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, hcb_pkg::OFS_IRQ_CLR, 32'h2);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      apb(1'b0, hcb_pkg::OFS_STATUS, 32'h0);
      chk(rv & 32'h2, 32'h0, "source driven idle");
      $display("test interrupt done");
      tally_and_finish;
   end
endmodule
`default_nettype wire
